// ### padoi_pkg.sv
// Purpose: Shared constants for the converter output interface and its capture end.
// Assumes: One convert clock CLK, synchronous active-low reset NRST.
// Notes: Codes are straight offset binary.
package padoi_pkg;
   localparam int WIDTH = 8;
   localparam int STAGES = 7;
   localparam int LATENCY = 5;
   localparam logic [7:0] CODE_FS_POS = 8'hff;
   localparam logic [7:0] CODE_MID = 8'h80;
   localparam logic [7:0] CODE_FS_NEG = 8'h00;
   localparam logic [7:0] CODE_ZERO = 8'h00;
   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] CNT_LAT = 3'h5;
   localparam logic [1:0] STAGE_ZERO = 2'h0;
endpackage

// ### padoi_if.sv
// Purpose: Pins between the converter and its capture logic.
// Assumes: Data pins are three-state; the enable marks driving.
// Notes: Pull-downs on the enable and power-down pins are modelled as defaults.
`timescale 1ns/1ps
interface padoi_if;
   logic [7:0] data_o;
   logic data_oe;
   logic oe_n;
   logic pwrdn;
   modport converter (output data_o, output data_oe, input oe_n, input pwrdn);
   modport capture (input data_o, input data_oe, output oe_n, output pwrdn);
endinterface

// ### padoi_capture.sv
// Purpose: Capture end that drives the control pins and latches converter words.
// Assumes: Shares CLK with the converter, which acts as the convert clock.
// Notes: Data pins come from the converter on the same clock, so no synchroniser.
`timescale 1ns/1ps
module padoi_capture (
   // Clock and reset.
   input wire logic CLK,
   input wire logic NRST,
   // User controls.
   input wire logic PWRDN_REQ,
   input wire logic TEST_TRISTATE,
   // Captured samples.
   output logic [7:0] SAMPLE,
   output logic SAMPLE_VALID,
   // Converter pins.
   padoi_if.capture pins
);
   logic [2:0] warm_reg;
   logic [2:0] warm_next;
   logic [7:0] sample_reg;
   logic valid_reg;
   logic warm_done;
   logic word_ok;

   // Power-down is a plain level request; enable held static from a test input.
   assign pins.pwrdn = PWRDN_REQ;
   assign pins.oe_n = TEST_TRISTATE;

   // Words count only after five clocks out of power-down.
   assign warm_done = (warm_reg == padoi_pkg::CNT_LAT);
   assign warm_next = PWRDN_REQ ? padoi_pkg::CNT_ZERO :
                      (warm_done ? warm_reg : warm_reg + padoi_pkg::CNT_ONE);
   assign word_ok = warm_done && !PWRDN_REQ && pins.data_oe;

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         warm_reg <= padoi_pkg::CNT_ZERO;
         sample_reg <= padoi_pkg::CODE_ZERO;
         valid_reg <= 1'b0;
      end else begin
         warm_reg <= warm_next;
         sample_reg <= pins.data_o;
         valid_reg <= word_ok;
      end
   end

   assign SAMPLE = sample_reg;
   assign SAMPLE_VALID = valid_reg;
endmodule

// ### padoi_converter.sv
// Purpose: Digital side of an 8-bit pipelined converter: pipeline, coding, output drive.
// Assumes: The quantised input arrives each clock as an unsigned offset binary code.
// Notes: Seven stages of two bits with one redundant bit, aligned and corrected.
`timescale 1ns/1ps
module padoi_converter (
   // Clock and reset.
   input wire logic CLK,
   input wire logic NRST,
   // Sampled analog value in code form.
   input wire logic [7:0] ANALOG_CODE,
   // Output pins.
   padoi_if.converter pins
);
   // Input sample and the residues handed between pipeline steps.
   logic [7:0] samp_reg;
   logic [8:0] res0;
   logic [8:0] res1;
   logic [8:0] res2;
   logic [8:0] res3_next;
   logic [8:0] res3_reg;
   logic [8:0] res4;
   logic [8:0] res5_next;
   logic [8:0] res5_reg;
   logic [8:0] res6;
   logic [8:0] res7_next;
   logic [8:0] res7_reg;
   // Stage digits as they leave their quantisers.
   logic [1:0] dig0_next;
   logic [1:0] dig1_next;
   logic [1:0] dig2_next;
   logic [1:0] dig3_next;
   logic [1:0] dig4_next;
   logic [1:0] dig5_next;
   logic [1:0] dig6_next;
   // Delay lines that align earlier digits with later ones.
   logic [1:0] dig0_s1_reg;
   logic [1:0] dig1_s1_reg;
   logic [1:0] dig2_s1_reg;
   logic [1:0] dig0_s2_reg;
   logic [1:0] dig1_s2_reg;
   logic [1:0] dig2_s2_reg;
   logic [1:0] dig3_s2_reg;
   logic [1:0] dig4_s2_reg;
   logic [1:0] dig0_s3_reg;
   logic [1:0] dig1_s3_reg;
   logic [1:0] dig2_s3_reg;
   logic [1:0] dig3_s3_reg;
   logic [1:0] dig4_s3_reg;
   logic [1:0] dig5_s3_reg;
   logic [1:0] dig6_s3_reg;
   // Weighted terms, their sum and the corrected word.
   logic [9:0] term0;
   logic [9:0] term1;
   logic [9:0] term2;
   logic [9:0] term3;
   logic [9:0] term4;
   logic [9:0] term5;
   logic [9:0] term6;
   logic [9:0] code_sum;
   logic [7:0] corrected;
   logic [7:0] out_reg;
   // Pin levels seen through the modelled pull-downs.
   logic pd_in;
   logic oe_in;

   // Undriven pulled-down pins read as low.
   assign pd_in = (pins.pwrdn === 1'b1);
   assign oe_in = (pins.oe_n === 1'b1);

   // Stage weights halve from the first stage to the last.
   function automatic logic [8:0] padoi_weight(input int k);
      padoi_weight = 9'(1 << (padoi_pkg::STAGES - 1 - k));
   endfunction

   // Error correction saturates the digit sum to the eight-bit range.
   function automatic logic [7:0] padoi_correct(input logic [9:0] total);
      padoi_correct = (total > 10'h0ff) ? padoi_pkg::CODE_FS_POS : total[7:0];
   endfunction

   // Two-bit sub-quantiser with one overlapping code for redundancy.
   function automatic logic [1:0] padoi_stage(input logic [8:0] r, input int k);
      logic [8:0] w;
      w = padoi_weight(k);
      padoi_stage = (r >= 9'(w << 1)) ? 2'h2 : ((r >= w) ? 2'h1 : padoi_pkg::STAGE_ZERO);
   endfunction

   // Residue left for the next stage once a digit is taken out.
   function automatic logic [8:0] padoi_resid(input logic [8:0] r, input logic [1:0] d, input int k);
      padoi_resid = r - 9'(d * padoi_weight(k));
   endfunction

   // Weighted value of one digit at the width of the sum.
   function automatic logic [9:0] padoi_term(input logic [1:0] d, input int k);
      padoi_term = 10'(d * padoi_weight(k));
   endfunction

   // First step: stages zero to two work on the held sample.
   assign res0 = {1'b0, samp_reg};
   assign dig0_next = padoi_stage(res0, 0);
   assign res1 = padoi_resid(res0, dig0_next, 0);
   assign dig1_next = padoi_stage(res1, 1);
   assign res2 = padoi_resid(res1, dig1_next, 1);
   assign dig2_next = padoi_stage(res2, 2);
   assign res3_next = padoi_resid(res2, dig2_next, 2);

   // Second step: stages three and four.
   assign dig3_next = padoi_stage(res3_reg, 3);
   assign res4 = padoi_resid(res3_reg, dig3_next, 3);
   assign dig4_next = padoi_stage(res4, 4);
   assign res5_next = padoi_resid(res4, dig4_next, 4);

   // Third step: stages five and six.
   assign dig5_next = padoi_stage(res5_reg, 5);
   assign res6 = padoi_resid(res5_reg, dig5_next, 5);
   assign dig6_next = padoi_stage(res6, 6);
   assign res7_next = padoi_resid(res6, dig6_next, 6);

   // Correction adds the aligned digit weights and the final residue.
   assign term0 = padoi_term(dig0_s3_reg, 0);
   assign term1 = padoi_term(dig1_s3_reg, 1);
   assign term2 = padoi_term(dig2_s3_reg, 2);
   assign term3 = padoi_term(dig3_s3_reg, 3);
   assign term4 = padoi_term(dig4_s3_reg, 4);
   assign term5 = padoi_term(dig5_s3_reg, 5);
   assign term6 = padoi_term(dig6_s3_reg, 6);
   assign code_sum = term0 + term1 + term2 + term3
                     + term4 + term5 + term6 + {1'b0, res7_reg};
   assign corrected = padoi_correct(code_sum);

   // Sample register: conversion starts on the clock edge.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         samp_reg <= padoi_pkg::CODE_MID;
      end else begin
         samp_reg <= ANALOG_CODE;
      end
   end

   // First step registers.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         res3_reg <= {1'b0, padoi_pkg::CODE_MID};
         dig0_s1_reg <= padoi_pkg::STAGE_ZERO;
         dig1_s1_reg <= padoi_pkg::STAGE_ZERO;
         dig2_s1_reg <= padoi_pkg::STAGE_ZERO;
      end else begin
         res3_reg <= res3_next;
         dig0_s1_reg <= dig0_next;
         dig1_s1_reg <= dig1_next;
         dig2_s1_reg <= dig2_next;
      end
   end

   // Second step registers.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         res5_reg <= {1'b0, padoi_pkg::CODE_MID};
         dig0_s2_reg <= padoi_pkg::STAGE_ZERO;
         dig1_s2_reg <= padoi_pkg::STAGE_ZERO;
         dig2_s2_reg <= padoi_pkg::STAGE_ZERO;
         dig3_s2_reg <= padoi_pkg::STAGE_ZERO;
         dig4_s2_reg <= padoi_pkg::STAGE_ZERO;
      end else begin
         res5_reg <= res5_next;
         dig0_s2_reg <= dig0_s1_reg;
         dig1_s2_reg <= dig1_s1_reg;
         dig2_s2_reg <= dig2_s1_reg;
         dig3_s2_reg <= dig3_next;
         dig4_s2_reg <= dig4_next;
      end
   end

   // Third step registers.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         res7_reg <= {1'b0, padoi_pkg::CODE_MID};
         dig0_s3_reg <= padoi_pkg::STAGE_ZERO;
         dig1_s3_reg <= padoi_pkg::STAGE_ZERO;
         dig2_s3_reg <= padoi_pkg::STAGE_ZERO;
         dig3_s3_reg <= padoi_pkg::STAGE_ZERO;
         dig4_s3_reg <= padoi_pkg::STAGE_ZERO;
         dig5_s3_reg <= padoi_pkg::STAGE_ZERO;
         dig6_s3_reg <= padoi_pkg::STAGE_ZERO;
      end else begin
         res7_reg <= res7_next;
         dig0_s3_reg <= dig0_s2_reg;
         dig1_s3_reg <= dig1_s2_reg;
         dig2_s3_reg <= dig2_s2_reg;
         dig3_s3_reg <= dig3_s2_reg;
         dig4_s3_reg <= dig4_s2_reg;
         dig5_s3_reg <= dig5_next;
         dig6_s3_reg <= dig6_next;
      end
   end

   // Output register: fourth edge after the sample edge, cleared in power-down.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         out_reg <= padoi_pkg::CODE_MID;
      end else begin
         out_reg <= pd_in ? padoi_pkg::CODE_ZERO : corrected;
      end
   end

   assign pins.data_o = out_reg;
   assign pins.data_oe = !oe_in && !pd_in;
endmodule

// ### padoi_asserts.sv
// Purpose: Pin checks between the converter and its capture end.
// Assumes: One clock, synchronous active-low reset.
// Notes: Sees only the interface signals.
`timescale 1ns/1ps
module padoi_asserts (
   // Clock and reset.
   input wire logic CLK,
   input wire logic NRST,
   // Pins.
   input wire logic [7:0] data_o,
   input wire logic data_oe,
   input wire logic oe_n,
   input wire logic pwrdn
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   sequence s_wake; pwrdn ##1 (!pwrdn && !oe_n); endsequence
   sequence s_pd2; pwrdn [*2]; endsequence
   property p_oe_off; oe_n |-> !data_oe; endproperty
   property p_drive; (!oe_n && !pwrdn) |-> data_oe; endproperty
   property p_pd_off; pwrdn |-> !data_oe; endproperty
   property p_pd_zero; s_pd2 |-> data_o == 8'h00; endproperty
   property p_wake; s_wake |-> data_oe; endproperty
   property p_rst_mid; $rose(NRST) |-> data_o == 8'h80; endproperty
   property p_oe_back; oe_n ##1 (!oe_n && !pwrdn) |-> data_oe; endproperty
   property p_pd_long; pwrdn [*3] |-> !data_oe && $stable(data_o); endproperty
   a_oe_off: assert property (p_oe_off) else $error("driving while disabled");
   a_drive: assert property (p_drive) else $error("not driving");
   a_pd_off: assert property (p_pd_off) else $error("driving in power-down");
   a_pd_zero: assert property (p_pd_zero) else $error("data not cleared");
   a_wake: assert property (p_wake) else $error("no drive after wake");
   a_rst_mid: assert property (p_rst_mid) else $error("reset word wrong");
   a_oe_back: assert property (p_oe_back) else $error("drive not restored");
   a_pd_long: assert property (p_pd_long) else $error("power-down unsteady");
endmodule

// ### tb_top.sv
// Purpose: Drives both ends and checks latency, coding and enables.
// Assumes: The capture end makes the control pins.
// Notes: Expected words come from a history of driven codes.
`timescale 1ns/1ps
module tb_top;
   logic CLK = 1'b0, NRST = 1'b0, pd = 1'b0, ts = 1'b0, vld;
   logic [7:0] code = 8'h80, smp;
   logic [7:0] hist[$] = '{8{8'h80}};
   logic [7:0] tab[8] = '{8'hff, 8'h80, 8'h00, 8'hc0, 8'h40, 8'he0, 8'h20, 8'h01};
   int n_errors = 0, check_count = 0, q = 0, tq = 0;
   padoi_if pins ();
   padoi_converter i_padoi_converter (.CLK(CLK), .NRST(NRST), .ANALOG_CODE(code), .pins(pins));
   padoi_capture i_padoi_capture (.CLK(CLK), .NRST(NRST), .PWRDN_REQ(pd), .TEST_TRISTATE(ts),
      .SAMPLE(smp), .SAMPLE_VALID(vld), .pins(pins));
   padoi_asserts i_padoi_asserts (.CLK(CLK), .NRST(NRST), .data_o(pins.data_o),
      .data_oe(pins.data_oe), .oe_n(pins.oe_n), .pwrdn(pins.pwrdn));
   always #50 CLK = ~CLK;
   // Counts quiet edges since reset or power-down, and since tristate.
   always @(posedge CLK) begin
      q <= (!NRST || pd) ? 0 : q + 1;
      tq <= ts ? 0 : tq + 1;
   end
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task give_verdict;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Streams fixed codes then every code, with power-down and tristate spells.
   initial begin
      repeat (12) @(negedge CLK);
      NRST = 1'b1;
      for (int i = 0; i < 330; i++) begin
         @(negedge CLK);
         chk("data_oe", {7'h0, pins.data_oe}, {7'h0, !pd && !ts});
         if (q >= 5) chk("data_o", pins.data_o, hist[4]);
         chk("valid", {7'h0, vld}, {7'h0, q >= 6 && tq >= 1});
         if (q >= 6 && tq >= 1) chk("sample", smp, hist[5]);
         pd = i >= 280 && i < 290;
         ts = i >= 300 && i < 304;
         code = i < 8 ? tab[i] : 8'(i);
         hist.push_front(code);
      end
      give_verdict();
   end
   // Stops a hung run.
   initial begin
      #100000;
      n_errors++;
      give_verdict();
   end
endmodule
